/* oppo_pkg.sv */
// Constants shared by the optical port and pulse output block
package oppo_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Register byte addresses
  localparam logic [15:0] ADDR_PULSE_CFG = 16'h2004;
  localparam logic [15:0] ADDR_TX_CFG = 16'h2007;
  localparam logic [15:0] ADDR_OPT_CFG = 16'h2008;
  localparam logic [15:0] ADDR_MAX_WIDTH = 16'h2080;
  localparam logic [15:0] ADDR_TIMEBASE = 16'h2081;
  localparam logic [15:0] ADDR_STATUS = 16'h2090;
  // Field positions
  localparam int BIT_PULSE_INV = 6;
  localparam int BIT_TX_SEL_LO = 6;
  localparam int BIT_DUTY_LO = 0;
  localparam int BIT_TX_INV = 0;
  localparam int BIT_TX_MOD = 1;
  localparam int BIT_RX_INV = 4;
  localparam int BIT_RX_GPIO = 5;
  localparam int BIT_ST_WATT = 0;
  localparam int BIT_ST_VAR = 1;
  localparam int BIT_ST_RX = 2;
  localparam int BIT_ST_TX = 3;
  // Reset values
  localparam logic [7:0] RST_MAX_WIDTH = 8'hff;
  localparam logic [7:0] RST_TIMEBASE = 8'h00;
  localparam logic [1:0] RST_TX_SEL = 2'h0;
  localparam logic [1:0] RST_DUTY = 2'h0;
  // Width setting that turns limiting off
  localparam logic [7:0] MAXW_NO_LIMIT = 8'hff;
  // Pacing queue depth and carrier shape
  localparam int PEND_W = 4;
  localparam logic [3:0] PEND_MAX = 4'hf;
  localparam int MOD_W = 4;
  localparam logic [3:0] MOD_LOW_CODE0 = 4'h8;
  localparam logic [3:0] MOD_LOW_CODE1 = 4'h4;
  localparam logic [3:0] MOD_LOW_CODE2 = 4'h2;
  localparam logic [3:0] MOD_LOW_CODE3 = 4'h1;
  typedef enum logic [1:0] {
    TX_SRC_UART,
    TX_SRC_GPIO,
    TX_SRC_WATT,
    TX_SRC_VAR
  } oppo_tx_src_t;
  typedef enum {
    SH_IDLE,
    SH_ACTIVE
  } oppo_shape_state_t;
endpackage

/* oppo_shaper_if.sv */
// Link between the control logic and one pulse shaper
`timescale 1ns/100ps
`default_nettype none
interface oppo_shaper_if;
  logic [7:0] max_width;
  logic bypass;
  logic t1_tick;
  logic ce_pulse;
  logic active;
  logic [3:0] pending;
  modport ctrl (
    output max_width, bypass, t1_tick, ce_pulse,
    input active, pending
  );
  modport shaper (
    input max_width, bypass, t1_tick, ce_pulse,
    output active, pending
  );
endinterface
`default_nettype wire

/* oppo_pulse_shaper.sv */
// One metering pulse shaper with pacing queue and width limit
`timescale 1ns/100ps
`default_nettype none
module oppo_pulse_shaper (
  input wire logic clk_i,
  input wire logic srst_i,
  oppo_shaper_if.shaper sif
);
  import oppo_pkg::*;

  oppo_shape_state_t state_q, state_d;
  logic [8:0] width_q, width_d;
  logic [3:0] pend_q, pend_d;
  logic level_q, level_d;
  logic active_q;
  logic no_limit;
  logic release_now;

  ////////////////////////////////////////////////////////////////////////////
  assign no_limit = (sif.max_width == MAXW_NO_LIMIT);
  // Bypass releases on the next cycle; paced mode waits for a T1 edge
  assign release_now = (state_q == SH_IDLE) && (pend_q != '0) &&
                       (sif.bypass || sif.t1_tick); // [RULE11]

  always_comb begin
    pend_d = pend_q;
    // Saturate rather than wrap so a burst never turns into zero pulses
    if (sif.ce_pulse && !release_now && pend_q != PEND_MAX) begin
      pend_d = pend_q + 4'h1;
    end else if (!sif.ce_pulse && release_now) begin
      pend_d = pend_q - 4'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    width_d = width_q;
    level_d = level_q;
    if (no_limit) begin
      state_d = SH_IDLE;
      if (release_now) begin
        level_d = !level_q; // [RULE9]
      end
    end else if (release_now) begin
      state_d = SH_ACTIVE;
      width_d = {sif.max_width, 1'b1}; // [RULE7]
    end else if (state_q == SH_ACTIVE && sif.t1_tick) begin
      if (width_q == 9'h001) begin
        state_d = SH_IDLE;
      end else begin
        width_d = width_q - 9'h001; // [RULE7]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= SH_IDLE;
      width_q <= '0;
      pend_q <= '0;
      level_q <= 1'b0;
    end else begin
      state_q <= state_d;
      width_q <= width_d;
      pend_q <= pend_d;
      level_q <= level_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= no_limit ? level_d : (state_d == SH_ACTIVE);
    end
  end

  assign sif.active = active_q;
  assign sif.pending = pend_q;
endmodule // oppo_pulse_shaper
`default_nettype wire

/* oppo_top.sv */
// Optical port pin conditioning and metering pulse outputs
//
// Notes on behaviour
// RULE1: Receive pin feeds the UART comparator when clear, is GPIO when set.
// RULE2: Receive invert flips only the UART value, never the GPIO value.
// RULE3: Transmit select picks UART, GPIO, watt or var pulse for the pin.
// RULE4: Transmit invert applies before modulation.
// RULE5: With modulation on, zero intervals become carrier; ones pass.
// RULE6: Duty field sets carrier low fraction; code 10 is 12.5%, 11 is 6.25%.
// RULE7: Pulse active time is at most (2 x max width + 1) T1 periods.
// RULE8: With timebase setting zero, T1 is one sample period.
// RULE9: Max width 255 disables limiting; pulses toggle for 50% duty.
// RULE10: Software must set timebase to 81 when using the pacing queue.
// RULE11: Timebase zero bypasses pacing; pulses leave as soon as issued.
// RULE12: Pulse outputs are active low, active high when pulse invert set.
// RULE13: In GPIO mode the transmit pin follows GPIO output, unshaped.
`timescale 1ns/100ps
`default_nettype none
module oppo_top (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [oppo_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [oppo_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [oppo_pkg::DATA_W-1:0] RDATA_O,
  input wire logic SAMPLE_TICK_I,
  input wire logic CE_WATT_PULSE_I,
  input wire logic CE_VAR_PULSE_I,
  input wire logic UART_TXD_I,
  output logic UART_RXD_O,
  input wire logic GPIO_LINE_ONE_OUT_I,
  input wire logic GPIO_LINE_ONE_DRIVE_I,
  output logic GPIO_LINE_ONE_IN_O,
  input wire logic GPIO_LINE_TWO_OUT_I,
  input wire logic GPIO_LINE_TWO_DRIVE_I,
  output logic GPIO_LINE_TWO_IN_O,
  input wire logic OPTICAL_RECEIVE_PIN_I,
  output logic OPTICAL_RECEIVE_PIN_O,
  output logic OPTICAL_RECEIVE_PIN_OE_N_O,
  input wire logic OPTICAL_TRANSMIT_PIN_I,
  output logic OPTICAL_TRANSMIT_PIN_O,
  output logic OPTICAL_TRANSMIT_PIN_OE_N_O,
  output logic WATT_PULSE_OUT_O,
  output logic VAR_PULSE_OUT_O
);
  import oppo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier low count for each duty code
  function automatic logic [3:0] duty_low(input logic [1:0] code);
    logic [3:0] r;
    r = MOD_LOW_CODE0;
    case (code)
      2'h0: r = MOD_LOW_CODE0;
      2'h1: r = MOD_LOW_CODE1;
      2'h2: r = MOD_LOW_CODE2;
      default: r = MOD_LOW_CODE3;
    endcase
    return r;
  endfunction

  // Pin level for a shaped pulse under the chosen polarity
  function automatic logic pulse_level(input logic act, input logic inv);
    return inv ? act : !act;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic pulse_polarity_invert_q;
  oppo_tx_src_t optical_tx_source_select_q;
  logic [1:0] modulation_duty_select_q;
  logic optical_tx_invert_q;
  logic optical_tx_modulate_enable_q;
  logic optical_rx_invert_q;
  logic optical_rx_pin_as_gpio_q;
  logic [7:0] pulse_max_width_q;
  logic [7:0] pulse_width_timebase_q;
  logic [7:0] rdata_d;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pulse_polarity_invert_q <= 1'b0;
      optical_tx_source_select_q <= oppo_tx_src_t'(RST_TX_SEL);
      modulation_duty_select_q <= RST_DUTY;
      optical_tx_invert_q <= 1'b0;
      optical_tx_modulate_enable_q <= 1'b0;
      optical_rx_invert_q <= 1'b0;
      optical_rx_pin_as_gpio_q <= 1'b0;
      pulse_max_width_q <= RST_MAX_WIDTH;
      pulse_width_timebase_q <= RST_TIMEBASE;
    end else if (WR_I) begin
      if (ADDR_I == ADDR_PULSE_CFG) begin
        pulse_polarity_invert_q <= WDATA_I[BIT_PULSE_INV];
      end else if (ADDR_I == ADDR_TX_CFG) begin
        optical_tx_source_select_q <=
          oppo_tx_src_t'(WDATA_I[BIT_TX_SEL_LO +: 2]);
        modulation_duty_select_q <= WDATA_I[BIT_DUTY_LO +: 2];
      end else if (ADDR_I == ADDR_OPT_CFG) begin
        optical_tx_invert_q <= WDATA_I[BIT_TX_INV];
        optical_tx_modulate_enable_q <= WDATA_I[BIT_TX_MOD];
        optical_rx_invert_q <= WDATA_I[BIT_RX_INV];
        optical_rx_pin_as_gpio_q <= WDATA_I[BIT_RX_GPIO];
      end else if (ADDR_I == ADDR_MAX_WIDTH) begin
        pulse_max_width_q <= WDATA_I;
      end else if (ADDR_I == ADDR_TIMEBASE) begin
        // Pacing only behaves as intended at the value software must use
        pulse_width_timebase_q <= WDATA_I; // [RULE10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic rx_meta_q, rx_sync_q;
  logic tx_meta_q, tx_sync_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
      tx_meta_q <= 1'b0;
      tx_sync_q <= 1'b0;
    end else begin
      rx_meta_q <= OPTICAL_RECEIVE_PIN_I;
      rx_sync_q <= rx_meta_q;
      tx_meta_q <= OPTICAL_TRANSMIT_PIN_I;
      tx_sync_q <= tx_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Width time base: one tick every T1
  logic [7:0] t1_cnt_q;
  logic t1_tick;
  logic timebase_zero;

  assign timebase_zero = (pulse_width_timebase_q == '0);
  assign t1_tick = SAMPLE_TICK_I &&
                   (timebase_zero ||
                    t1_cnt_q == pulse_width_timebase_q - 8'h01); // [RULE8]

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      t1_cnt_q <= '0;
    end else if (timebase_zero || t1_tick) begin
      t1_cnt_q <= '0;
    end else if (SAMPLE_TICK_I) begin
      t1_cnt_q <= t1_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse shapers
  oppo_shaper_if watt_if ();
  oppo_shaper_if var_if ();

  assign watt_if.max_width = pulse_max_width_q;
  assign watt_if.bypass = timebase_zero; // [RULE11]
  assign watt_if.t1_tick = t1_tick;
  assign watt_if.ce_pulse = CE_WATT_PULSE_I;
  assign var_if.max_width = pulse_max_width_q;
  assign var_if.bypass = timebase_zero; // [RULE11]
  assign var_if.t1_tick = t1_tick;
  assign var_if.ce_pulse = CE_VAR_PULSE_I;

  oppo_pulse_shaper u_watt_shaper (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .sif(watt_if.shaper)
  );

  oppo_pulse_shaper u_var_shaper (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .sif(var_if.shaper)
  );

  logic watt_level, var_level;
  assign watt_level = pulse_level(watt_if.active,
                                  pulse_polarity_invert_q); // [RULE12]
  assign var_level = pulse_level(var_if.active,
                                 pulse_polarity_invert_q); // [RULE12]

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      WATT_PULSE_OUT_O <= 1'b1;
      VAR_PULSE_OUT_O <= 1'b1;
    end else begin
      WATT_PULSE_OUT_O <= watt_level;
      VAR_PULSE_OUT_O <= var_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulation carrier, free running
  logic [MOD_W-1:0] mod_cnt_q;
  logic carrier;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      mod_cnt_q <= '0;
    end else begin
      mod_cnt_q <= mod_cnt_q + 4'h1;
    end
  end

  assign carrier = (mod_cnt_q >=
                    duty_low(modulation_duty_select_q)); // [RULE6]

  ////////////////////////////////////////////////////////////////////////////
  // Transmit pin
  logic tx_src, tx_inv, tx_shaped;

  always_comb begin
    tx_src = UART_TXD_I;
    case (optical_tx_source_select_q)
      TX_SRC_UART: tx_src = UART_TXD_I; // [RULE3]
      TX_SRC_GPIO: tx_src = GPIO_LINE_TWO_OUT_I; // [RULE3]
      TX_SRC_WATT: tx_src = watt_level; // [RULE3]
      default: tx_src = var_level; // [RULE3]
    endcase
  end

  assign tx_inv = tx_src ^ optical_tx_invert_q; // [RULE4]
  assign tx_shaped = tx_inv |
                     (optical_tx_modulate_enable_q & carrier); // [RULE5]

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      OPTICAL_TRANSMIT_PIN_O <= 1'b1;
      OPTICAL_TRANSMIT_PIN_OE_N_O <= 1'b1;
    end else if (optical_tx_source_select_q == TX_SRC_GPIO) begin
      // Raw GPIO path keeps software in full control of the pin
      OPTICAL_TRANSMIT_PIN_O <= GPIO_LINE_TWO_OUT_I; // [RULE13]
      OPTICAL_TRANSMIT_PIN_OE_N_O <= !GPIO_LINE_TWO_DRIVE_I; // [RULE13]
    end else begin
      OPTICAL_TRANSMIT_PIN_O <= tx_shaped;
      OPTICAL_TRANSMIT_PIN_OE_N_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive pin
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      UART_RXD_O <= 1'b1;
      GPIO_LINE_ONE_IN_O <= 1'b0;
      GPIO_LINE_TWO_IN_O <= 1'b0;
      OPTICAL_RECEIVE_PIN_O <= 1'b0;
      OPTICAL_RECEIVE_PIN_OE_N_O <= 1'b1;
    end else begin
      GPIO_LINE_TWO_IN_O <= tx_sync_q;
      if (optical_rx_pin_as_gpio_q) begin
        // UART sees idle so a stray edge cannot start a frame
        UART_RXD_O <= 1'b1; // [RULE1]
        GPIO_LINE_ONE_IN_O <= rx_sync_q; // [RULE2]
        OPTICAL_RECEIVE_PIN_O <= GPIO_LINE_ONE_OUT_I; // [RULE1]
        OPTICAL_RECEIVE_PIN_OE_N_O <= !GPIO_LINE_ONE_DRIVE_I; // [RULE1]
      end else begin
        UART_RXD_O <= rx_sync_q ^ optical_rx_invert_q; // [RULE1] [RULE2]
        GPIO_LINE_ONE_IN_O <= 1'b0;
        OPTICAL_RECEIVE_PIN_O <= 1'b0;
        OPTICAL_RECEIVE_PIN_OE_N_O <= 1'b1; // [RULE1]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read, data one cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (ADDR_I == ADDR_PULSE_CFG) begin
      rdata_d[BIT_PULSE_INV] = pulse_polarity_invert_q;
    end else if (ADDR_I == ADDR_TX_CFG) begin
      rdata_d[BIT_TX_SEL_LO +: 2] = optical_tx_source_select_q;
      rdata_d[BIT_DUTY_LO +: 2] = modulation_duty_select_q;
    end else if (ADDR_I == ADDR_OPT_CFG) begin
      rdata_d[BIT_TX_INV] = optical_tx_invert_q;
      rdata_d[BIT_TX_MOD] = optical_tx_modulate_enable_q;
      rdata_d[BIT_RX_INV] = optical_rx_invert_q;
      rdata_d[BIT_RX_GPIO] = optical_rx_pin_as_gpio_q;
    end else if (ADDR_I == ADDR_MAX_WIDTH) begin
      rdata_d = pulse_max_width_q;
    end else if (ADDR_I == ADDR_TIMEBASE) begin
      rdata_d = pulse_width_timebase_q;
    end else if (ADDR_I == ADDR_STATUS) begin
      rdata_d[BIT_ST_WATT] = watt_if.active;
      rdata_d[BIT_ST_VAR] = var_if.active;
      rdata_d[BIT_ST_RX] = rx_sync_q;
      rdata_d[BIT_ST_TX] = tx_sync_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      RDATA_O <= rdata_d;
    end else begin
      RDATA_O <= '0;
    end
  end
endmodule // oppo_top
`default_nettype wire

/* oppo_chk.sv */
// Port checker for the optical port and pulse output block
`timescale 1ns/100ps
`default_nettype none
module oppo_chk (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [oppo_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [oppo_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [oppo_pkg::DATA_W-1:0] RDATA_O,
  input wire logic CE_WATT_PULSE_I,
  input wire logic UART_TXD_I,
  input wire logic UART_RXD_O,
  input wire logic GPIO_LINE_TWO_OUT_I,
  input wire logic GPIO_LINE_TWO_DRIVE_I,
  input wire logic OPTICAL_RECEIVE_PIN_I,
  input wire logic OPTICAL_TRANSMIT_PIN_O,
  input wire logic OPTICAL_TRANSMIT_PIN_OE_N_O,
  input wire logic WATT_PULSE_OUT_O
);
  import oppo_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow registers, so no design internals are needed
  logic [7:0] r4_q, r7_q, r8_q, r80_q, r81_q;
  // Cycles since the last write; paths settle before checks apply
  logic [2:0] age_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      r4_q <= 8'h00;
      r7_q <= 8'h00;
      r8_q <= 8'h00;
      r80_q <= 8'hff;
      r81_q <= 8'h00;
    end else if (WR_I) begin
      if (ADDR_I == ADDR_PULSE_CFG) r4_q <= WDATA_I;
      if (ADDR_I == ADDR_TX_CFG) r7_q <= WDATA_I;
      if (ADDR_I == ADDR_OPT_CFG) r8_q <= WDATA_I;
      if (ADDR_I == ADDR_MAX_WIDTH) r80_q <= WDATA_I;
      if (ADDR_I == ADDR_TIMEBASE) r81_q <= WDATA_I;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || WR_I) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  rd_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data not zero outside read");
  rd_width_a: assert property (
    RD_I && ADDR_I == ADDR_MAX_WIDTH |=> RDATA_O == r80_q)
    else $error("width setting read back wrong");
  rx_gpio_a: assert property (
    r8_q[5] && age_q > 3'h1 |-> UART_RXD_O)
    else $error("uart receive not idle in gpio mode");
  rx_inv_a: assert property (
    !r8_q[5] && age_q > 3'h3
    |-> UART_RXD_O == ($past(OPTICAL_RECEIVE_PIN_I, 3) ^ r8_q[4]))
    else $error("uart receive level wrong");
  tx_uart_a: assert property (
    r7_q[7:6] == 2'h0 && !r8_q[1] && age_q > 3'h1
    |-> !OPTICAL_TRANSMIT_PIN_OE_N_O
    && OPTICAL_TRANSMIT_PIN_O == ($past(UART_TXD_I) ^ r8_q[0]))
    else $error("transmit pin not uart level");
  tx_gpio_a: assert property (
    r7_q[7:6] == 2'h1 && age_q > 3'h1
    |-> OPTICAL_TRANSMIT_PIN_O == $past(GPIO_LINE_TWO_OUT_I)
    && OPTICAL_TRANSMIT_PIN_OE_N_O == !$past(GPIO_LINE_TWO_DRIVE_I))
    else $error("transmit pin not gpio level");
  tx_mod_one_a: assert property (
    r7_q[7:6] == 2'h0 && r8_q[1] && age_q > 3'h1
    && ($past(UART_TXD_I) ^ r8_q[0]) |-> OPTICAL_TRANSMIT_PIN_O)
    else $error("modulated pin low while signal high");
  pulse_fast_a: assert property (
    r81_q == 8'h00 && r80_q != MAXW_NO_LIMIT && age_q > 3'h1
    && CE_WATT_PULSE_I && !$past(CE_WATT_PULSE_I)
    && WATT_PULSE_OUT_O == !r4_q[6] && $past(WATT_PULSE_OUT_O) == !r4_q[6]
    |-> ##3 WATT_PULSE_OUT_O == r4_q[6])
    else $error("watt pulse late");
endmodule // oppo_chk
bind oppo_top oppo_chk oppo_chk_i (.CLK_SYS_I, .SRST_I, .ADDR_I, .WDATA_I,
  .WR_I, .RD_I, .RDATA_O, .CE_WATT_PULSE_I, .UART_TXD_I, .UART_RXD_O,
  .GPIO_LINE_TWO_OUT_I, .GPIO_LINE_TWO_DRIVE_I, .OPTICAL_RECEIVE_PIN_I,
  .OPTICAL_TRANSMIT_PIN_O, .OPTICAL_TRANSMIT_PIN_OE_N_O, .WATT_PULSE_OUT_O);
`default_nettype wire

/* oppo_partner.sv */
// Optical transceiver model on the far side of the optical pins
`timescale 1ns/100ps
`default_nettype none
module oppo_partner (
  input wire logic comp_i,
  input wire logic rx_drv_i,
  input wire logic rx_oe_n_i,
  input wire logic tx_drv_i,
  input wire logic tx_oe_n_i,
  output logic rx_pin_o,
  output logic tx_pin_o
);
  logic tx_last = 1'b0;
  // Device output wins while it drives the receive pin
  assign rx_pin_o = rx_oe_n_i ? comp_i : rx_drv_i;
  always @(tx_drv_i, tx_oe_n_i) if (!tx_oe_n_i) tx_last = tx_drv_i;
  // LED line has no pull, so a floating line shows the opposite level
  assign tx_pin_o = tx_oe_n_i ? !tx_last : tx_drv_i;
endmodule // oppo_partner
`default_nettype wire

/* oppo_top_tb.sv */
// Self-checking bench for the optical port and pulse output block
`timescale 1ns/100ps
`default_nettype none
module oppo_top_tb;
  import oppo_pkg::*;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0;
  logic cew = 1'b0, cev = 1'b0, utx = 1'b1, comp = 1'b1;
  logic g1o = 1'b0, g1d = 1'b0, g2o = 1'b0, g2d = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic urx, g1i, g2i, rxp, rxo, rxoe, txp, txo, txoe, wp, vp;
  int n_fail = 0, samples_checked = 0, seed = 32'hf1921b2c;
  int tc = 0, cyc = 0, i, n;
  logic [15:0] ra [6] = '{ADDR_PULSE_CFG, ADDR_TX_CFG, ADDR_OPT_CFG,
    ADDR_MAX_WIDTH, ADDR_TIMEBASE, 16'h2005};
  logic [7:0] rm [6] = '{8'h40, 8'hc3, 8'h33, 8'hff, 8'hff, 8'h00};
  logic [7:0] md [6] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  oppo_top oppo_top_i (.CLK_SYS_I(clk), .SRST_I(srst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SAMPLE_TICK_I(tick), .CE_WATT_PULSE_I(cew), .CE_VAR_PULSE_I(cev),
    .UART_TXD_I(utx), .UART_RXD_O(urx), .GPIO_LINE_ONE_OUT_I(g1o),
    .GPIO_LINE_ONE_DRIVE_I(g1d), .GPIO_LINE_ONE_IN_O(g1i),
    .GPIO_LINE_TWO_OUT_I(g2o), .GPIO_LINE_TWO_DRIVE_I(g2d),
    .GPIO_LINE_TWO_IN_O(g2i), .OPTICAL_RECEIVE_PIN_I(rxp),
    .OPTICAL_RECEIVE_PIN_O(rxo), .OPTICAL_RECEIVE_PIN_OE_N_O(rxoe),
    .OPTICAL_TRANSMIT_PIN_I(txp), .OPTICAL_TRANSMIT_PIN_O(txo),
    .OPTICAL_TRANSMIT_PIN_OE_N_O(txoe), .WATT_PULSE_OUT_O(wp),
    .VAR_PULSE_OUT_O(vp));
  oppo_partner oppo_partner_i (.comp_i(comp), .rx_drv_i(rxo),
    .rx_oe_n_i(rxoe), .tx_drv_i(txo), .tx_oe_n_i(txoe), .rx_pin_o(rxp),
    .tx_pin_o(txp));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  // Sample tick every 4 cycles keeps the long time base runs short
  always @(posedge clk) begin
    tc <= (tc + 1) % 4;
    tick <= (tc == 3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_all;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      addr <= ra[k];
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, md[k]);
    end
  endtask
  task automatic fire(input bit var_sel);
    @(posedge clk iff tick);
    if (var_sel) cev <= 1'b1;
    else cew <= 1'b1;
    @(posedge clk);
    cev <= 1'b0;
    cew <= 1'b0;
  endtask
  // Counts sample ticks seen while the chosen pin is active
  task automatic meas(input bit var_sel, input int exp, input logic act);
    int m;
    m = 0;
    for (int k = 0; k < 9999; k++) begin
      @(negedge clk);
      if ((var_sel ? vp : wp) === act) break;
    end
    while ((var_sel ? vp : wp) === act && m < 999) begin
      m += tick;
      @(negedge clk);
    end
    chk(m, exp);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd_all();
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      wr_reg(ra[i], v);
      md[i] = v & rm[i];
    end
    rd_all();
    for (i = 0; i < 5; i++) wr_reg(ra[i], 8'h00);
    for (i = 0; i < 16; i++) begin
      wr_reg(ADDR_OPT_CFG, {2'b00, i[1], i[0], 4'h0});
      comp <= 1'($random(seed));
      g1o <= 1'($random(seed));
      g1d <= i[2];
      repeat (5) @(posedge clk);
      #1;
      v[0] = (i[1] && i[2]) ? g1o : comp;
      chk(urx, i[1] ? 1'b1 : v[0] ^ i[0]);
      chk(g1i, i[1] ? v[0] : 1'b0);
      chk(rxoe, !(i[1] && i[2]));
    end
    wr_reg(ADDR_OPT_CFG, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr_reg(ADDR_TX_CFG, {i[1:0], 6'h00});
      wr_reg(ADDR_OPT_CFG, {7'h00, i[2]});
      utx <= 1'($random(seed));
      g2o <= 1'($random(seed));
      g2d <= i[3];
      repeat (5) @(posedge clk);
      #1;
      v[0] = (i[1:0] == 1) ? g2o : (i[1] ? 1'b1 : utx) ^ i[2];
      chk(txo, v[0]);
      chk(txoe, (i[1:0] == 1) ? !g2d : 1'b0);
      // Undriven pin shows whatever the far side leaves on it
      chk(g2i, (i[1:0] == 1 && !i[3]) ? txp : v[0]);
    end
    for (i = 0; i < 16; i++) begin
      wr_reg(ADDR_TX_CFG, {6'h00, i[3:2]});
      wr_reg(ADDR_OPT_CFG, {6'h00, 1'b1, i[0]});
      utx <= i[1];
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16) begin
        @(negedge clk);
        n += (txo === 1'b0);
      end
      chk(n, (i[1] ^ i[0]) ? 0 : 8 >> i[3:2]);
    end
    for (i = 0; i < 3; i++) begin
      wr_reg(ADDR_MAX_WIDTH, 8'(i * i));
      fire(1'b0);
      meas(1'b0, 2 * i * i + 1, 1'b0);
    end
    wr_reg(ADDR_PULSE_CFG, 8'h40);
    wr_reg(ADDR_MAX_WIDTH, 8'h02);
    fire(1'b1);
    meas(1'b1, 5, 1'b1);
    wr_reg(ADDR_PULSE_CFG, 8'h00);
    wr_reg(ADDR_MAX_WIDTH, 8'hff);
    for (i = 0; i < 2; i++) begin
      fire(1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk(wp, i[0]);
      @(posedge clk);
      addr <= ADDR_STATUS;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata[1:0], {1'b0, !i[0]});
    end
    wr_reg(ADDR_MAX_WIDTH, 8'h00);
    wr_reg(ADDR_TIMEBASE, 8'h51);
    fork
      repeat (3) fire(1'b1);
      repeat (3) meas(1'b1, 81, 1'b0);
    join
    end_of_test();
  end
endmodule // oppo_top_tb
`default_nettype wire
